// [sps_pkg.sv]
`default_nettype none

// ----------------------------------------------------------------------------
// Shared constants and types of the serial port status block.
// ----------------------------------------------------------------------------
package sps_pkg;

   // ------------------------------------------------------------------------
   // Register byte offsets on the bus.
   // ------------------------------------------------------------------------
   localparam logic [7:0] SPS_OFS_STATUS = 8'h00;
   localparam logic [7:0] SPS_OFS_CONTROL = 8'h04;
   localparam logic [7:0] SPS_OFS_ADDRESS = 8'h08;
   localparam logic [7:0] SPS_OFS_BUFFER = 8'h0C;
   localparam logic [7:0] SPS_OFS_ACTIVE = 8'h10;

   // ------------------------------------------------------------------------
   // Field positions of serial_port_status.
   // ------------------------------------------------------------------------
   localparam int SPS_ST_BF = 0;
   localparam int SPS_ST_UA = 1;
   localparam int SPS_ST_RW = 2;
   localparam int SPS_ST_START = 3;
   localparam int SPS_ST_STOP = 4;
   localparam int SPS_ST_DA = 5;
   localparam int SPS_ST_SMBUS = 6;
   localparam int SPS_ST_SLEW = 7;

   // ------------------------------------------------------------------------
   // Field positions of the control register.
   // ------------------------------------------------------------------------
   localparam int SPS_CT_SEQ_LO = 0;
   localparam int SPS_CT_SEQ_HI = 4;
   localparam int SPS_CT_RCV = 3;
   localparam int SPS_CT_MASTER = 8;
   localparam int SPS_CT_ADDR10 = 9;
   localparam int SPS_CT_EN = 15;

   // ------------------------------------------------------------------------
   // Values after reset and bus framing constants.
   // ------------------------------------------------------------------------
   localparam logic [15:0] SPS_CONTROL_RST = 16'h0000;
   localparam logic [9:0] SPS_ADDRESS_RST = 10'h000;
   localparam logic [7:0] SPS_BUFFER_RST = 8'h00;
   localparam logic [3:0] SPS_BITS_PER_BYTE = 4'h8;
   localparam logic [4:0] SPS_TEN_BIT_PREFIX = 5'h1E;
   localparam int SPS_NUM_EVT = 4;
   localparam int SPS_EV_START = 0;
   localparam int SPS_EV_STOP = 1;
   localparam int SPS_EV_BYTE = 2;
   localparam int SPS_EV_ACK = 3;

   // ------------------------------------------------------------------------
   // Slave address phase and bus request carrier.
   // ------------------------------------------------------------------------
   typedef enum logic [3:0] {
      SPS_PH_IDLE = 4'h1,
      SPS_PH_ADDR = 4'h2,
      SPS_PH_ADDR2 = 4'h4,
      SPS_PH_DATA = 4'h8
   } sps_phase_e;

   typedef struct packed {
      logic cyc;
      logic stb;
      logic we;
      logic [7:0] adr;
      logic [3:0] sel;
      logic [31:0] dat;
   } sps_wb_req_s;

endpackage

`default_nettype wire

// [sps_evt_sync.sv]
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------------------------------------------
// Toggle event crossing into the destination clock domain.
// ----------------------------------------------------------------------------
module sps_evt_sync (
   input wire logic clk_in,
   input wire logic rst_in,
   input wire logic toggle_in,
   output logic pulse_out
);

   logic meta_reg;
   logic sync_reg;
   logic last_reg;

   // Two flops settle the toggle; the third only remembers the last level.
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         meta_reg <= 1'b0;
         sync_reg <= 1'b0;
         last_reg <= 1'b0;
      end else begin
         meta_reg <= toggle_in;
         sync_reg <= meta_reg;
         last_reg <= sync_reg;
      end
   end

   // Each change of the source toggle gives one destination pulse.
   assign pulse_out = sync_reg ^ last_reg;

endmodule // sps_evt_sync

`default_nettype wire

// [sps_status_flags.sv]
// Design decisions made here: the Wishbone register port and the register offsets.
`timescale 1ns/1ps
`default_nettype none

// How it works
// - Slave: data flag high after a data byte, low after an address byte.
// - Slave: direction flag takes the address byte read/write bit on match.
// - Direction is trusted only until the next start, stop or nack.
// - Master: direction flag shows whether a transmission is in progress.
// - Master activity is direction flag OR any sequence enable.
// - Transmit: buffer full from buffer load until the byte has gone.
// - Transmit complete clears buffer full.
// - Receive: buffer full once a whole byte is in; ack and stop excluded.
// - Start and stop flags clear on reset and while the port is disabled.
// - Writable SMBus select bit drives input behaviour, resets to zero.
module sps_status_flags (
   input wire logic clk_sys_in,
   input wire logic sys_rst_in,
   input wire sps_pkg::sps_wb_req_s wb_req_in,
   output logic [31:0] wb_dat_out,
   output logic wb_ack_out,
   input wire logic link_clk_in,
   input wire logic scl_in,
   input wire logic sda_in,
   output logic smbus_select_out,
   output logic port_active_out
);
   import sps_pkg::*;

   // ------------------------------------------------------------------------
   // Link domain: pin sampling, start and stop detection, bit counting.
   // ------------------------------------------------------------------------
   logic lrst_meta_reg;
   logic lrst_reg;
   logic scl_meta_reg;
   logic scl_sync_reg;
   logic scl_last_reg;
   logic sda_meta_reg;
   logic sda_sync_reg;
   logic sda_last_reg;
   logic [3:0] bit_cnt_reg;
   logic [7:0] shift_reg;
   logic [7:0] byte_hold_reg;
   logic nack_hold_reg;
   logic [SPS_NUM_EVT-1:0] tog_reg;
   wire bus_start;
   wire bus_stop;
   wire scl_rise;

   // Reset reaches the link logic at once but leaves it on a link edge.
   always_ff @(posedge link_clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         lrst_meta_reg <= 1'b1;
         lrst_reg <= 1'b1;
      end else begin
         lrst_meta_reg <= 1'b0;
         lrst_reg <= lrst_meta_reg;
      end
   end

   // Pins are asynchronous to everything, so two flops before any decode.
   always_ff @(posedge link_clk_in or posedge lrst_reg) begin
      if (lrst_reg) begin
         scl_meta_reg <= 1'b1;
         scl_sync_reg <= 1'b1;
         scl_last_reg <= 1'b1;
         sda_meta_reg <= 1'b1;
         sda_sync_reg <= 1'b1;
         sda_last_reg <= 1'b1;
      end else begin
         scl_meta_reg <= scl_in;
         scl_sync_reg <= scl_meta_reg;
         scl_last_reg <= scl_sync_reg;
         sda_meta_reg <= sda_in;
         sda_sync_reg <= sda_meta_reg;
         sda_last_reg <= sda_sync_reg;
      end
   end

   // Data moving while the clock line is high marks start or stop.
   assign bus_start = scl_sync_reg & scl_last_reg & sda_last_reg & ~sda_sync_reg;
   assign bus_stop = scl_sync_reg & scl_last_reg & ~sda_last_reg & sda_sync_reg;
   assign scl_rise = scl_sync_reg & ~scl_last_reg;

   // Eight rising clocks make a byte; the ninth carries the acknowledge.
   always_ff @(posedge link_clk_in or posedge lrst_reg) begin
      if (lrst_reg) begin
         bit_cnt_reg <= 4'h0;
         shift_reg <= 8'h00;
         byte_hold_reg <= 8'h00;
         nack_hold_reg <= 1'b0;
         tog_reg <= '0;
      end else if (bus_start || bus_stop) begin
         bit_cnt_reg <= 4'h0;
         tog_reg[SPS_EV_START] <= tog_reg[SPS_EV_START] ^ bus_start;
         tog_reg[SPS_EV_STOP] <= tog_reg[SPS_EV_STOP] ^ bus_stop;
      end else if (scl_rise && bit_cnt_reg == SPS_BITS_PER_BYTE) begin
         bit_cnt_reg <= 4'h0;
         nack_hold_reg <= sda_sync_reg;
         tog_reg[SPS_EV_ACK] <= ~tog_reg[SPS_EV_ACK];
      end else if (scl_rise) begin
         bit_cnt_reg <= bit_cnt_reg + 4'h1;
         shift_reg <= {shift_reg[6:0], sda_sync_reg};
         if (bit_cnt_reg == SPS_BITS_PER_BYTE - 4'h1) begin
            byte_hold_reg <= {shift_reg[6:0], sda_sync_reg};
            tog_reg[SPS_EV_BYTE] <= ~tog_reg[SPS_EV_BYTE];
         end
      end
   end

   // ------------------------------------------------------------------------
   // Event crossing into the system domain.
   // ------------------------------------------------------------------------
   logic [SPS_NUM_EVT-1:0] ev_pulse;

   // The held byte and ack bit stay still for a whole bit time after their
   // toggle, far longer than the three system edges the crossing takes.
   for (genvar gi = 0; gi < SPS_NUM_EVT; gi++) begin : g_evt
      sps_evt_sync u_evt (
         .clk_in(clk_sys_in),
         .rst_in(sys_rst_in),
         .toggle_in(tog_reg[gi]),
         .pulse_out(ev_pulse[gi])
      );
   end

   // ------------------------------------------------------------------------
   // Bus slave decode.
   // ------------------------------------------------------------------------
   logic [15:0] ctrl_reg;
   logic [9:0] addr_reg;
   logic slew_reg;
   logic smbus_reg;
   logic [7:0] buf_reg;
   wire wb_hit;
   wire wb_wr;
   wire wb_rd;
   wire sel_status;
   wire sel_control;
   wire sel_address;
   wire sel_buffer;
   wire sel_active;
   wire port_en;
   wire master_mode;
   wire addr10_mode;
   wire buf_write;
   wire buf_read;

   assign wb_hit = wb_req_in.cyc & wb_req_in.stb & ~wb_ack_out;
   assign wb_wr = wb_hit & wb_req_in.we;
   assign wb_rd = wb_hit & ~wb_req_in.we;
   assign sel_status = wb_req_in.adr == SPS_OFS_STATUS;
   assign sel_control = wb_req_in.adr == SPS_OFS_CONTROL;
   assign sel_address = wb_req_in.adr == SPS_OFS_ADDRESS;
   assign sel_buffer = wb_req_in.adr == SPS_OFS_BUFFER;
   assign sel_active = wb_req_in.adr == SPS_OFS_ACTIVE;
   assign port_en = ctrl_reg[SPS_CT_EN];
   assign master_mode = ctrl_reg[SPS_CT_MASTER];
   assign addr10_mode = ctrl_reg[SPS_CT_ADDR10];
   assign buf_write = wb_wr & sel_buffer & wb_req_in.sel[0];
   assign buf_read = wb_rd & sel_buffer;

   // Software configuration; byte enables pick the lanes written.
   always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         ctrl_reg <= SPS_CONTROL_RST;
         addr_reg <= SPS_ADDRESS_RST;
         slew_reg <= 1'b0;
         smbus_reg <= 1'b0;
      end else begin
         if (wb_wr && sel_control && wb_req_in.sel[0])
            ctrl_reg[7:0] <= wb_req_in.dat[7:0];
         if (wb_wr && sel_control && wb_req_in.sel[1])
            ctrl_reg[15:8] <= wb_req_in.dat[15:8];
         if (wb_wr && sel_address && wb_req_in.sel[0])
            addr_reg[7:0] <= wb_req_in.dat[7:0];
         if (wb_wr && sel_address && wb_req_in.sel[1])
            addr_reg[9:8] <= wb_req_in.dat[9:8];
         if (wb_wr && sel_status && wb_req_in.sel[0]) begin
            slew_reg <= wb_req_in.dat[SPS_ST_SLEW];
            smbus_reg <= wb_req_in.dat[SPS_ST_SMBUS];
         end
      end
   end

   // ------------------------------------------------------------------------
   // Start and stop flags.
   // ------------------------------------------------------------------------
   logic start_reg;
   logic stop_reg;

   // A disabled port shows neither flag; the later condition wins, and start wins if both arrive in the same cycle.
   always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         start_reg <= 1'b0;
         stop_reg <= 1'b0;
      end else if (!port_en) begin
         start_reg <= 1'b0;
         stop_reg <= 1'b0;
      end else if (ev_pulse[SPS_EV_START]) begin
         start_reg <= 1'b1;
         stop_reg <= 1'b0;
      end else if (ev_pulse[SPS_EV_STOP]) begin
         start_reg <= 1'b0;
         stop_reg <= 1'b1;
      end
   end

   // ------------------------------------------------------------------------
   // Slave address tracking, direction and data flags.
   // ------------------------------------------------------------------------
   sps_phase_e phase_reg;
   logic rw_reg;
   logic rw_valid_reg;
   logic da_reg;
   logic ua_reg;
   wire [7:0] rx_byte;
   wire match7;
   wire match10_hi;
   wire match10_lo;
   wire slave_byte;
   wire slave_nack;
   wire ua_set;

   assign rx_byte = byte_hold_reg;
   assign match7 = rx_byte[7:1] == addr_reg[6:0];
   assign match10_hi = rx_byte[7:3] == SPS_TEN_BIT_PREFIX && rx_byte[2:1] == addr_reg[9:8];
   assign match10_lo = rx_byte == addr_reg[7:0];
   assign slave_byte = port_en & ~master_mode & ev_pulse[SPS_EV_BYTE];
   assign slave_nack = ev_pulse[SPS_EV_ACK] & nack_hold_reg;
   // Both address bytes of a 10-bit match ask software to refresh the address.
   assign ua_set = slave_byte & addr10_mode & ((phase_reg == SPS_PH_ADDR & match10_hi & ~rx_byte[0])
      | (phase_reg == SPS_PH_ADDR2 & match10_lo));

   // The direction bit is kept but its validity ends at start, stop or nack.
   always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         phase_reg <= SPS_PH_IDLE;
         rw_reg <= 1'b0;
         rw_valid_reg <= 1'b0;
         da_reg <= 1'b0;
      end else if (!port_en || master_mode) begin
         phase_reg <= SPS_PH_IDLE;
         rw_valid_reg <= 1'b0;
         da_reg <= 1'b0;
      end else if (ev_pulse[SPS_EV_START]) begin
         phase_reg <= SPS_PH_ADDR;
         rw_valid_reg <= 1'b0;
      end else if (ev_pulse[SPS_EV_STOP] || slave_nack) begin
         phase_reg <= SPS_PH_IDLE;
         rw_valid_reg <= 1'b0;
      end else if (slave_byte) begin
         case (phase_reg)
            SPS_PH_ADDR: begin
               da_reg <= 1'b0;
               if (addr10_mode && match10_hi && !rx_byte[0]) begin
                  phase_reg <= SPS_PH_ADDR2;
               end else if ((addr10_mode && match10_hi) || (!addr10_mode && match7)) begin
                  phase_reg <= SPS_PH_DATA;
                  rw_reg <= rx_byte[0];
                  rw_valid_reg <= 1'b1;
               end else begin
                  phase_reg <= SPS_PH_IDLE;
               end
            end
            SPS_PH_ADDR2: begin
               da_reg <= 1'b0;
               phase_reg <= match10_lo ? SPS_PH_DATA : SPS_PH_IDLE;
               rw_reg <= 1'b0;
               rw_valid_reg <= match10_lo;
            end
            SPS_PH_DATA: begin
               da_reg <= 1'b1;
            end
            default: begin
               phase_reg <= SPS_PH_IDLE;
            end
         endcase
      end
   end

   // Address refresh request; a new match wins over a same-cycle rewrite.
   always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
      if (sys_rst_in)
         ua_reg <= 1'b0;
      else if (!port_en || !addr10_mode)
         ua_reg <= 1'b0;
      else if (ua_set)
         ua_reg <= 1'b1;
      else if (wb_wr && sel_address)
         ua_reg <= 1'b0;
   end

   // ------------------------------------------------------------------------
   // Buffer full and master transmit tracking.
   // ------------------------------------------------------------------------
   logic bf_reg;
   logic tx_busy_reg;
   wire slave_tx;
   wire tx_mode;
   wire tx_done;
   wire rx_done;

   // Transmit and receive decode use direction only inside its valid window, so a stale bit is inert here.
   assign slave_tx = ~master_mode & rw_valid_reg & rw_reg;
   assign tx_mode = master_mode ? tx_busy_reg : slave_tx;
   assign tx_done = port_en & ev_pulse[SPS_EV_BYTE] & tx_mode;
   assign rx_done = port_en & ev_pulse[SPS_EV_BYTE] & ~tx_mode
      & (master_mode ? ctrl_reg[SPS_CT_RCV] : (phase_reg == SPS_PH_DATA && rw_valid_reg));

   // A byte arriving in the same cycle as a buffer read still sets the flag.
   always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         bf_reg <= 1'b0;
         tx_busy_reg <= 1'b0;
         buf_reg <= SPS_BUFFER_RST;
      end else if (!port_en) begin
         bf_reg <= 1'b0;
         tx_busy_reg <= 1'b0;
      end else if (buf_write && (master_mode || slave_tx)) begin
         bf_reg <= 1'b1;
         tx_busy_reg <= master_mode;
         buf_reg <= wb_req_in.dat[7:0];
      end else if (tx_done) begin
         bf_reg <= 1'b0;
         tx_busy_reg <= 1'b0;
      end else if (rx_done) begin
         bf_reg <= 1'b1;
         buf_reg <= rx_byte;
      end else if (buf_read && !tx_mode) begin
         bf_reg <= 1'b0;
      end
   end

   // ------------------------------------------------------------------------
   // Read data, acknowledge and registered outputs.
   // ------------------------------------------------------------------------
   wire rw_view;
   wire active_next;
   wire [15:0] status_word;
   wire [31:0] rd_word;

   assign rw_view = master_mode ? tx_busy_reg : rw_reg;
   assign active_next = port_en & master_mode
      & (tx_busy_reg | (|ctrl_reg[SPS_CT_SEQ_HI:SPS_CT_SEQ_LO]));
   assign status_word = {8'h00, slew_reg, smbus_reg, da_reg, stop_reg, start_reg,
      rw_view, ua_reg, bf_reg};
   // Unmapped offsets read zero and still answer, so the master never hangs.
   assign rd_word = sel_status ? {16'h0000, status_word}
      : sel_control ? {16'h0000, ctrl_reg}
      : sel_address ? {22'h000000, addr_reg}
      : sel_buffer ? {24'h000000, buf_reg}
      : sel_active ? {31'h00000000, port_active_out}
      : 32'h00000000;

   // One wait state: the answer comes on the edge after the request is seen.
   always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         wb_ack_out <= 1'b0;
         wb_dat_out <= 32'h00000000;
         smbus_select_out <= 1'b0;
         port_active_out <= 1'b0;
      end else begin
         wb_ack_out <= wb_hit;
         wb_dat_out <= wb_rd ? rd_word : 32'h00000000;
         smbus_select_out <= smbus_reg;
         port_active_out <= active_next;
      end
   end

   // ------------------------------------------------------------------------
   // Assertions.
   // ------------------------------------------------------------------------
   default clocking cb_sys @(posedge clk_sys_in); endclocking
   default disable iff (sys_rst_in);

   sequence s_addr_match;
      slave_byte && phase_reg == SPS_PH_ADDR && !addr10_mode && match7
         && !ev_pulse[SPS_EV_START] && !ev_pulse[SPS_EV_STOP] && !slave_nack;
   endsequence

   sequence s_data_byte;
      slave_byte && phase_reg == SPS_PH_DATA && !ev_pulse[SPS_EV_START]
         && !ev_pulse[SPS_EV_STOP] && !slave_nack;
   endsequence

   bus_answer_a: assert property (wb_hit |=> wb_ack_out ##1 !wb_ack_out)
      else $error("bus answer not a single cycle");
   rw_capture_a: assert property (s_addr_match |=> rw_valid_reg
      && rw_reg == $past(rx_byte[0]) && !da_reg)
      else $error("direction bit not captured at address match");
   data_flag_a: assert property (s_data_byte |=> da_reg)
      else $error("data flag not set after data byte");
   rw_window_a: assert property ((ev_pulse[SPS_EV_STOP] || slave_nack) |=> !rw_valid_reg)
      else $error("direction still valid after stop or nack");
   stop_order_a: assert property (port_en && ev_pulse[SPS_EV_STOP] && !ev_pulse[SPS_EV_START]
      |=> stop_reg && !start_reg)
      else $error("stop did not replace start");
   disable_clr_a: assert property (!port_en |=> !start_reg && !stop_reg)
      else $error("start or stop flag set while disabled");
   master_load_a: assert property (port_en && master_mode && buf_write
      |=> bf_reg && rw_view ##1 (bf_reg || $past(tx_done)))
      else $error("buffer full not held after load");
   tx_done_a: assert property (tx_done && master_mode |=> !bf_reg && !rw_view)
      else $error("buffer full not cleared at transmit end");
   rx_full_a: assert property (rx_done && !buf_write
      |=> bf_reg && buf_reg == $past(rx_byte))
      else $error("received byte not flagged");
   ua_mode_a: assert property (!addr10_mode |=> !ua_reg)
      else $error("address update outside 10-bit mode");
   active_view_a: assert property (##1 port_active_out == $past(active_next))
      else $error("active output wrong");
   smbus_sel_a: assert property (wb_wr && sel_status && wb_req_in.sel[0]
      |=> ##1 smbus_select_out == $past(wb_req_in.dat[SPS_ST_SMBUS], 2))
      else $error("smbus select not following write");

endmodule // sps_status_flags

`default_nettype wire

// [sps_bus_model.sv]
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------------------------------------------
// Bus master model driving both bus lines from the link clock.
// ----------------------------------------------------------------------------
module sps_bus_model (
   input wire logic link_clk_in,
   output logic scl_out,
   output logic sda_out
);
   localparam int HALF = 5;

   // Both lines idle high, as the pull-ups leave them.
   initial begin
      scl_out = 1'b1;
      sda_out = 1'b1;
   end

   // Each level is held for several link periods, so the two-flop sampler never misses it.
   task automatic hold();
      repeat (HALF) @(posedge link_clk_in);
   endtask

   task automatic put_bit(input logic b);
      sda_out <= b;
      hold();
      scl_out <= 1'b1;
      hold();
      scl_out <= 1'b0;
      hold();
   endtask

   // Start works as a repeated start too, since it raises both lines first.
   task automatic start_c();
      sda_out <= 1'b1;
      hold();
      scl_out <= 1'b1;
      hold();
      sda_out <= 1'b0;
      hold();
      scl_out <= 1'b0;
      hold();
   endtask

   task automatic stop_c();
      sda_out <= 1'b0;
      hold();
      scl_out <= 1'b1;
      hold();
      sda_out <= 1'b1;
      hold();
   endtask

   // Eight bits msb first, then a ninth bit in place of the answering slave.
   task automatic send_byte(input logic [7:0] v, input logic nack);
      for (int i = 7; i >= 0; i--) begin
         put_bit(v[i]);
      end
      put_bit(nack);
   endtask
endmodule // sps_bus_model

`default_nettype wire

// [test_sps_status_flags.sv]
`timescale 1ns/1ps
`default_nettype none

module test_sps_status_flags;
   import sps_pkg::*;
   logic clk_sys_in;
   logic sys_rst_in;
   logic link_clk;
   sps_wb_req_s req;
   logic [31:0] dat;
   logic ack;
   logic sel_out;
   logic act;
   logic scl;
   logic sda;
   int err_count;
   int compares;

   // ------------------------------------------------------------------------
   // Clocks, with the link clock offset so the two never line up.
   // ------------------------------------------------------------------------
   initial clk_sys_in = 1'b0;
   always #20 clk_sys_in = ~clk_sys_in;
   initial begin
      link_clk = 1'b0;
      #7;
      forever #16 link_clk = ~link_clk;
   end

   sps_status_flags dut (.clk_sys_in(clk_sys_in), .sys_rst_in(sys_rst_in), .wb_req_in(req),
      .wb_dat_out(dat), .wb_ack_out(ack), .link_clk_in(link_clk), .scl_in(scl), .sda_in(sda),
      .smbus_select_out(sel_out), .port_active_out(act));
   sps_bus_model bus (.link_clk_in(link_clk), .scl_out(scl), .sda_out(sda));

   // ------------------------------------------------------------------------
   // Checking and bus tasks.
   // ------------------------------------------------------------------------
   task automatic final_report();
      $display("errors %0d compares %0d", err_count, compares);
      if (err_count == 0 && compares > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input logic [31:0] m);
      compares++;
      if ((got & m) !== (exp & m)) begin
         err_count++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic chk1(input logic got, input logic exp);
      chk({31'h0, got}, {31'h0, exp}, 32'h0000_0001);
   endtask

   // A bounded wait for ack; read data is taken at the ack edge, then one idle cycle.
   task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d,
         output logic [31:0] q);
      int n;
      n = 0;
      // Model tasks return on link edges, so realign to a system edge first.
      @(posedge clk_sys_in);
      req <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: a, sel: 4'hF, dat: d};
      do begin
         @(posedge clk_sys_in);
         n++;
      end while (ack !== 1'b1 && n < 50);
      if (ack !== 1'b1) begin
         err_count++;
         final_report();
      end
      q = dat;
      req <= '0;
      @(posedge clk_sys_in);
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      wb(1'b1, a, d, q);
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
      logic [31:0] q;
      wb(1'b0, a, 32'h0, q);
      chk(q, e, m);
   endtask

   // Flags land within seven system cycles of a pin event.
   task automatic settle();
      repeat (10) @(posedge clk_sys_in);
   endtask

   // ------------------------------------------------------------------------
   // Main sequence.
   // ------------------------------------------------------------------------
   initial begin
      err_count = 0;
      compares = 0;
      req = '0;
      sys_rst_in = 1'b1;
      repeat (6) @(posedge clk_sys_in);
      sys_rst_in <= 1'b0;
      repeat (4) @(posedge clk_sys_in);
      rd(SPS_OFS_STATUS, 32'h0, 32'hFFFF_FFFF);
      chk1(sel_out, 1'b0);
      rd(8'h14, 32'h0, 32'hFFFF_FFFF);
      wr(SPS_OFS_STATUS, 32'h40);
      rd(SPS_OFS_STATUS, 32'h40, 32'hFF);
      chk1(sel_out, 1'b1);
      wr(SPS_OFS_STATUS, 32'h0);
      // Slave with a 7-bit address: write transfer, then a read address.
      wr(SPS_OFS_CONTROL, 32'h8000);
      wr(SPS_OFS_ADDRESS, 32'h2A);
      bus.start_c();
      settle();
      rd(SPS_OFS_STATUS, 32'h08, 32'hFF);
      bus.send_byte(8'h54, 1'b0);
      settle();
      rd(SPS_OFS_STATUS, 32'h08, 32'hFF);
      bus.send_byte(8'hA5, 1'b0);
      settle();
      rd(SPS_OFS_STATUS, 32'h29, 32'hFF);
      rd(SPS_OFS_BUFFER, 32'hA5, 32'hFF);
      rd(SPS_OFS_STATUS, 32'h28, 32'hFF);
      bus.stop_c();
      settle();
      rd(SPS_OFS_STATUS, 32'h30, 32'hFB);
      bus.start_c();
      bus.send_byte(8'h55, 1'b0);
      settle();
      rd(SPS_OFS_STATUS, 32'h0C, 32'h3C);
      bus.stop_c();
      wr(SPS_OFS_CONTROL, 32'h0);
      rd(SPS_OFS_STATUS, 32'h04, 32'hFF);
      // Master transmit of one byte; busy and full until the byte has gone.
      wr(SPS_OFS_CONTROL, 32'h8100);
      wr(SPS_OFS_BUFFER, 32'h5A);
      rd(SPS_OFS_STATUS, 32'h05, 32'h07);
      chk1(act, 1'b1);
      bus.start_c();
      bus.send_byte(8'h5A, 1'b0);
      bus.stop_c();
      settle();
      rd(SPS_OFS_STATUS, 32'h10, 32'h1F);
      chk1(act, 1'b0);
      wr(SPS_OFS_CONTROL, 32'h8101);
      rd(SPS_OFS_ACTIVE, 32'h1, 32'hFFFF_FFFF);
      chk1(act, 1'b1);
      // Master receive: a whole byte fills the buffer even though it was refused.
      wr(SPS_OFS_CONTROL, 32'h8108);
      bus.start_c();
      bus.send_byte(8'h3C, 1'b1);
      settle();
      rd(SPS_OFS_STATUS, 32'h09, 32'h0F);
      rd(SPS_OFS_BUFFER, 32'h3C, 32'hFF);
      bus.stop_c();
      // Ten-bit slave: the first address byte asks for an address rewrite.
      wr(SPS_OFS_CONTROL, 32'h8200);
      wr(SPS_OFS_ADDRESS, 32'h12A);
      bus.start_c();
      bus.send_byte(8'hF2, 1'b0);
      settle();
      rd(SPS_OFS_STATUS, 32'h02, 32'h02);
      wr(SPS_OFS_ADDRESS, 32'h12A);
      rd(SPS_OFS_STATUS, 32'h0, 32'h02);
      bus.send_byte(8'h2A, 1'b0);
      settle();
      rd(SPS_OFS_STATUS, 32'h0A, 32'h2F);
      bus.stop_c();
      final_report();
   end
endmodule // test_sps_status_flags

`default_nettype wire
